// >>> hw/lc_pkg.sv
package lc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------
    localparam int LC_ADDR_W = 4;
    localparam logic [3:0] LC_OFS_FIRST_TABLE = 4'h0;
    localparam logic [3:0] LC_OFS_SECOND_TABLE = 4'h4;
    localparam logic [3:0] LC_OFS_CFG = 4'h8;
    localparam logic [3:0] LC_OFS_STATUS = 4'hC;

    // ------------------------------------------------------------
    // table sizes and reset values
    // ------------------------------------------------------------
    localparam int LC_WIDE_IN = 4;
    localparam int LC_COMB_IN = 3;
    localparam logic [15:0] LC_RST_TABLE = 16'h0000;
    localparam int LC_CFG_W = 19;
    localparam logic [18:0] LC_RST_CFG = 19'h00000;

    // ------------------------------------------------------------
    // configuration word fields
    // ------------------------------------------------------------
    localparam int LC_CFG_COMB_LSB = 0;
    localparam int LC_CFG_A_AUX = 8;
    localparam int LC_CFG_C_AUX = 9;
    localparam int LC_CFG_XSRC_LSB = 10;
    localparam int LC_CFG_YSRC_LSB = 12;
    localparam int LC_CFG_X_SET = 14;
    localparam int LC_CFG_Y_SET = 15;
    localparam int LC_CFG_LATCH = 16;
    localparam int LC_CFG_XOUT_COMB = 17;
    localparam int LC_CFG_YOUT_COMB = 18;

    // ------------------------------------------------------------
    // status word fields
    // ------------------------------------------------------------
    localparam int LC_ST_XQ = 0;
    localparam int LC_ST_YQ = 1;
    localparam int LC_ST_XOUT = 2;
    localparam int LC_ST_YOUT = 3;

    // low-voltage variant: storage may run as latches
    localparam logic LC_LATCH_CAPABLE = 1'b1;

    typedef enum logic [1:0] {
        LC_SRC_FIRST = 2'h0,
        LC_SRC_SECOND = 2'h1,
        LC_SRC_COMB = 2'h2,
        LC_SRC_DIRECT = 2'h3
    } lc_src_t;

    typedef struct packed {
        logic [7:0] comb_table;
        logic a_from_aux;
        logic c_from_aux;
        lc_src_t x_src;
        lc_src_t y_src;
        logic x_set;
        logic y_set;
        logic latch_mode;
        logic x_out_comb;
        logic y_out_comb;
    } lc_cfg_t;

    typedef struct packed {
        logic [3:0] first_table_inputs;
        logic [3:0] second_table_inputs;
        logic aux_input_one;
        logic aux_input_two;
        logic aux_input_three;
        logic direct_data;
    } lc_fab_t;

endpackage : lc_pkg

// >>> hw/lc_lut.sv
`timescale 1ns/100ps
module lc_lut #(
    parameter int N = 4
) (
    // contents
    input wire logic [(1<<N)-1:0] table_bits,
    // lookup
    input wire logic [N-1:0] sel,
    output logic out_bit
);
    // delay is the same whatever function is stored
    assign out_bit = table_bits[sel];
endmodule : lc_lut

// >>> hw/lc_store.sv
`timescale 1ns/100ps
module lc_store (
    // system
    input wire logic clk,
    input wire logic rst,
    // data and shared controls
    input wire logic d,
    input wire logic enable,
    input wire logic edge_hit,
    input wire logic gate_open,
    input wire logic latch_mode,
    input wire logic force_init,
    input wire logic init_val,
    // state
    output logic q
);
    logic q_reg;
    logic q_next;
    logic load;

    // latch follows d while the gate is high, flop only on the edge
    assign load = latch_mode ? gate_open : edge_hit;
    // init wins over enable; enable low holds q unless init is forced
    assign q_next = force_init ? init_val :
                    (enable & load) ? d : q_reg;
    assign q = q_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
        end
    end
endmodule : lc_store

// >>> hw/lc_logic_cell.sv
`timescale 1ns/100ps
module lc_logic_cell
    import lc_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [LC_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // fabric side
    input wire lc_fab_t fab_in,
    input wire logic storage_timing_input,
    input wire logic storage_update_allow,
    input wire logic preset_or_clear,
    input wire logic global_init,
    // cell outputs
    output logic x_out,
    output logic y_out,
    output logic xq_out,
    output logic yq_out
);

    // ------------------------------------------------------------
    // configuration state
    // ------------------------------------------------------------
    logic [15:0] first_table_reg;
    logic [15:0] first_table_next;
    logic [15:0] second_table_reg;
    logic [15:0] second_table_next;
    logic [LC_CFG_W-1:0] cfg_reg;
    logic [LC_CFG_W-1:0] cfg_next;
    lc_cfg_t cfg;

    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    // the struct is only a view of the stored word
    assign cfg.comb_table = cfg_reg[LC_CFG_COMB_LSB +: 8];
    assign cfg.a_from_aux = cfg_reg[LC_CFG_A_AUX];
    assign cfg.c_from_aux = cfg_reg[LC_CFG_C_AUX];
    assign cfg.x_src = lc_src_t'(cfg_reg[LC_CFG_XSRC_LSB +: 2]);
    assign cfg.y_src = lc_src_t'(cfg_reg[LC_CFG_YSRC_LSB +: 2]);
    assign cfg.x_set = cfg_reg[LC_CFG_X_SET];
    assign cfg.y_set = cfg_reg[LC_CFG_Y_SET];
    assign cfg.latch_mode = cfg_reg[LC_CFG_LATCH];
    assign cfg.x_out_comb = cfg_reg[LC_CFG_XOUT_COMB];
    assign cfg.y_out_comb = cfg_reg[LC_CFG_YOUT_COMB];

    // ------------------------------------------------------------
    // function generators
    // ------------------------------------------------------------
    logic first_val;
    logic second_val;
    logic comb_val;
    logic comb_a;
    logic comb_c;
    logic [LC_COMB_IN-1:0] comb_sel;

    lc_lut #(.N(LC_WIDE_IN)) u_first_lookup_table (
        .table_bits(first_table_reg),
        .sel(fab_in.first_table_inputs),
        .out_bit(first_val)
    );

    lc_lut #(.N(LC_WIDE_IN)) u_second_lookup_table (
        .table_bits(second_table_reg),
        .sel(fab_in.second_table_inputs),
        .out_bit(second_val)
    );

    // ------------------------------------------------------------
    // combining table inputs
    // ------------------------------------------------------------
    // steered inputs: table output or a cell input
    assign comb_a = cfg.a_from_aux ? fab_in.aux_input_two : first_val;
    assign comb_c = cfg.c_from_aux ? fab_in.aux_input_three :
                    second_val;
    // middle input always straight from the cell pin; with both tables
    // steered in, this gives 4+4+1 inputs, with both tables on the same four inputs and aux
    // input one as select bit, any five-input function
    assign comb_sel = {comb_c, fab_in.aux_input_one, comb_a};

    lc_lut #(.N(LC_COMB_IN)) u_combining_lookup_table (
        .table_bits(cfg.comb_table),
        .sel(comb_sel),
        .out_bit(comb_val)
    );

    // ------------------------------------------------------------
    // unregistered outputs
    // ------------------------------------------------------------
    // only two combinational paths leave; a third function has to be
    // taken out through a storage element
    assign x_out = cfg.x_out_comb ? comb_val : first_val;
    assign y_out = cfg.y_out_comb ? comb_val : second_val;

    // ------------------------------------------------------------
    // storage elements
    // ------------------------------------------------------------
    logic timing_prev_reg;
    logic timing_edge;
    logic init_force;
    logic latch_on;
    logic x_d;
    logic y_d;
    logic x_pick_first;
    logic x_pick_second;
    logic x_pick_comb;
    logic y_pick_first;
    logic y_pick_second;
    logic y_pick_comb;

    // one wire per source choice except the last, direct data, which has none
    assign x_pick_first = cfg.x_src == LC_SRC_FIRST;
    assign x_pick_second = cfg.x_src == LC_SRC_SECOND;
    assign x_pick_comb = cfg.x_src == LC_SRC_COMB;
    assign y_pick_first = cfg.y_src == LC_SRC_FIRST;
    assign y_pick_second = cfg.y_src == LC_SRC_SECOND;
    assign y_pick_comb = cfg.y_src == LC_SRC_COMB;

    // aux input one reaches either element through the combining table
    assign x_d = x_pick_first ? first_val :
                 x_pick_second ? second_val :
                 x_pick_comb ? comb_val :
                 fab_in.direct_data;
    assign y_d = y_pick_first ? first_val :
                 y_pick_second ? second_val :
                 y_pick_comb ? comb_val :
                 fab_in.direct_data;

    // ------------------------------------------------------------
    // shared controls
    // ------------------------------------------------------------
    // timing input is sampled on clk, so it must be slower than clk/2
    assign timing_edge = storage_timing_input & ~timing_prev_reg;
    assign init_force = global_init | preset_or_clear;
    assign latch_on = cfg.latch_mode & LC_LATCH_CAPABLE;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timing_prev_reg <= 1'b0;
        end else begin
            timing_prev_reg <= storage_timing_input;
        end
    end

    lc_store u_x_store (
        .clk(clk),
        .rst(rst),
        .d(x_d),
        .enable(storage_update_allow),
        .edge_hit(timing_edge),
        .gate_open(storage_timing_input),
        .latch_mode(latch_on),
        .force_init(init_force),
        .init_val(cfg.x_set),
        .q(xq_out)
    );

    lc_store u_y_store (
        .clk(clk),
        .rst(rst),
        .d(y_d),
        .enable(storage_update_allow),
        .edge_hit(timing_edge),
        .gate_open(storage_timing_input),
        .latch_mode(latch_on),
        .force_init(init_force),
        .init_val(cfg.y_set),
        .q(yq_out)
    );

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic wait_reg;
    logic wait_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic bus_req;
    logic wr_take;
    logic hit_first;
    logic hit_second;
    logic hit_cfg;
    logic hit_status;
    logic [31:0] be_mask;
    logic [31:0] merge_first;
    logic [31:0] merge_second;
    logic [31:0] merge_cfg;
    logic [31:0] status_word;
    logic rd_take;
    logic wr_first;
    logic wr_second;
    logic wr_cfg;
    logic [31:0] first_word;
    logic [31:0] second_word;
    logic [31:0] cfg_word;
    logic [31:0] hit_word;

    // ------------------------------------------------------------
    // handshake
    // ------------------------------------------------------------
    assign bus_req = read | write;
    // one wait cycle keeps read data a plain register
    assign wait_next = wait_reg ? ~bus_req : 1'b1;
    // a write lands only at the edge where waitrequest is seen low
    assign wr_take = write & ~wait_reg;
    // read data is loaded one edge early, so that it stands while
    // waitrequest is low
    assign rd_take = read & wait_reg;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    assign hit_first = address == LC_OFS_FIRST_TABLE;
    assign hit_second = address == LC_OFS_SECOND_TABLE;
    assign hit_cfg = address == LC_OFS_CFG;
    assign hit_status = address == LC_OFS_STATUS;
    // status gets no write strobe, so it stays read-only
    assign wr_first = wr_take & hit_first;
    assign wr_second = wr_take & hit_second;
    assign wr_cfg = wr_take & hit_cfg;

    // ------------------------------------------------------------
    // write path
    // ------------------------------------------------------------
    // bits above a register's width read zero and are dropped on write
    assign first_word = {16'h0000, first_table_reg};
    assign second_word = {16'h0000, second_table_reg};
    assign cfg_word = {13'h0000, cfg_reg};
    assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                      {8{byteenable[1]}}, {8{byteenable[0]}}};
    assign merge_first = (first_word & ~be_mask) | (writedata & be_mask);
    assign merge_second = (second_word & ~be_mask) | (writedata & be_mask);
    assign merge_cfg = (cfg_word & ~be_mask) | (writedata & be_mask);

    assign first_table_next = wr_first ? merge_first[15:0] : first_table_reg;
    assign second_table_next = wr_second ?
                               merge_second[15:0] : second_table_reg;
    assign cfg_next = wr_cfg ? merge_cfg[LC_CFG_W-1:0] : cfg_reg;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        status_word = 32'h00000000;
        status_word[LC_ST_XQ] = xq_out;
        status_word[LC_ST_YQ] = yq_out;
        status_word[LC_ST_XOUT] = x_out;
        status_word[LC_ST_YOUT] = y_out;
    end

    // unmapped addresses read zero and ignore writes
    assign hit_word = hit_first ? first_word :
                      hit_second ? second_word :
                      hit_cfg ? cfg_word :
                      hit_status ? status_word : 32'h00000000;
    // readdata holds between reads, so a late sample still sees it
    assign rdata_next = rd_take ? hit_word : rdata_reg;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            first_table_reg <= LC_RST_TABLE;
            second_table_reg <= LC_RST_TABLE;
            cfg_reg <= LC_RST_CFG;
            wait_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else begin
            first_table_reg <= first_table_next;
            second_table_reg <= second_table_next;
            cfg_reg <= cfg_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // bus outputs
    // ------------------------------------------------------------
    assign readdata = rdata_reg;
    assign waitrequest = wait_reg;

endmodule : lc_logic_cell

// >>> dv/lc_fab_model.sv
`timescale 1ns/100ps
// ----
// routing side: storage clock source
// ----
module lc_fab_model (
    // system
    input wire logic clk,
    input wire logic rst,
    // control from bench
    input wire logic run,
    input wire logic hold_high,
    // towards the cell
    output logic storage_timing_input
);
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    // still between bursts; each level lasts two clk, slower than clk/2
    assign cnt_next = run ? cnt_reg + 2'h1 : 2'h0;
    assign storage_timing_input = hold_high | cnt_reg[1];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 2'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : lc_fab_model

// >>> dv/lc_logic_cell_asserts.sv
`timescale 1ns/100ps
module lc_logic_cell_asserts
    import lc_pkg::*;
(
    // system and bus
    input wire logic clk,
    input wire logic rst,
    input wire logic [LC_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // cell side
    input wire logic storage_update_allow,
    input wire logic preset_or_clear,
    input wire logic global_init,
    input wire logic x_out,
    input wire logic y_out,
    input wire logic xq_out,
    input wire logic yq_out
);
    wire logic quiet = !storage_update_allow && !preset_or_clear
        && !global_init;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    bus_answer_a: assert property ((read || write) && waitrequest
        |=> !waitrequest) else $error("no answer after request");
    wait_pulse_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    idle_wait_a: assert property (!read && !write && waitrequest
        |=> waitrequest) else $error("answer without request");
    unmapped_zero_a: assert property (read && waitrequest
        && address[1:0] != 2'h0 |=> readdata == 32'h0)
        else $error("unmapped read not zero");
    status_view_a: assert property (
        read && waitrequest && address == LC_OFS_STATUS |=> readdata ==
        {28'h0, $past(y_out), $past(x_out), $past(yq_out), $past(xq_out)})
        else $error("status word mismatch");
    shared_hold_a: assert property (
        quiet |=> $stable(xq_out) && $stable(yq_out))
        else $error("storage changed while disabled");
    init_force_a: assert property (
        global_init [*2] |=> $stable(xq_out) && $stable(yq_out))
        else $error("storage not held by init");
    preset_force_a: assert property (
        preset_or_clear [*2] |=> $stable(xq_out) && $stable(yq_out))
        else $error("storage not held by set/reset");
endmodule : lc_logic_cell_asserts

bind lc_logic_cell lc_logic_cell_asserts u_chk (.clk, .rst, .address,
    .read, .write, .readdata, .waitrequest, .storage_update_allow,
    .preset_or_clear, .global_init, .x_out, .y_out, .xq_out, .yq_out);

// >>> dv/tb.sv
`timescale 1ns/100ps
module tb
    import lc_pkg::*;
;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [LC_ADDR_W-1:0] address = '0;
    logic read = 1'h0;
    logic write = 1'h0;
    logic [31:0] writedata = '0;
    logic [31:0] readdata;
    logic [31:0] rd;
    logic [3:0] byteenable = 4'hF;
    logic waitrequest, x_out, y_out, xq_out, yq_out, storage_timing_input;
    lc_fab_t fab = '0;
    logic storage_update_allow = 1'h0;
    logic preset_or_clear = 1'h0;
    logic global_init = 1'h0;
    logic run = 1'h0;
    logic hold_high = 1'h0;
    int mismatches = 0;
    int total_checks = 0;

    lc_logic_cell dut (.clk, .rst, .address, .read, .write, .writedata,
        .byteenable, .readdata, .waitrequest, .fab_in(fab),
        .storage_timing_input, .storage_update_allow, .preset_or_clear,
        .global_init, .x_out, .y_out, .xq_out, .yq_out);
    lc_fab_model fabric (.clk, .rst, .run, .hold_high,
        .storage_timing_input);

    initial begin
        forever #10 clk = ~clk;
    end

    // ----
    // helpers
    // ----
    task automatic chk(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= !wr;
        write <= wr;
        do @(posedge clk); while (waitrequest !== 1'h0);
        rd = readdata;
        read <= 1'h0;
        write <= 1'h0;
        @(posedge clk);
    endtask : bus

    function automatic logic [1:0] exp_xy(input logic [15:0] ft, st,
                                          input logic [31:0] c,
                                          input lc_fab_t f);
        logic fo, go, a, k, h;
        fo = ft[f.first_table_inputs];
        go = st[f.second_table_inputs];
        a = c[LC_CFG_A_AUX] ? f.aux_input_two : fo;
        k = c[LC_CFG_C_AUX] ? f.aux_input_three : go;
        h = c[{k, f.aux_input_one, a}];
        return {c[LC_CFG_YOUT_COMB] ? h : go, c[LC_CFG_XOUT_COMB] ? h : fo};
    endfunction : exp_xy

    task automatic logic_case(input logic [15:0] ft, st,
                              input logic [31:0] c);
        logic [1:0] e;
        bus(1'h1, LC_OFS_FIRST_TABLE, {16'h0, ft}, 4'hF);
        bus(1'h1, LC_OFS_SECOND_TABLE, {16'h0, st}, 4'hF);
        bus(1'h1, LC_OFS_CFG, c, 4'hF);
        repeat (8) begin
            fab <= 12'($urandom);
            @(negedge clk);
            e = exp_xy(ft, st, c, fab);
            chk("x_out", {31'h0, e[0]}, {31'h0, x_out});
            chk("y_out", {31'h0, e[1]}, {31'h0, y_out});
            @(posedge clk);
        end
    endtask : logic_case

    // m: 0 timing bursts, 1 set/reset, 2 global init, 3 latch gate open
    task automatic store(input logic [1:0] m, input logic en, dx, ay, ex, ey);
        fab.direct_data <= dx;
        fab.aux_input_one <= ay;
        storage_update_allow <= en;
        run <= (m == 2'h0);
        preset_or_clear <= (m == 2'h1);
        global_init <= (m == 2'h2);
        hold_high <= (m == 2'h3);
        repeat (10) @(posedge clk);
        {run, preset_or_clear, global_init, hold_high} <= 4'h0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("xq", {31'h0, ex}, {31'h0, xq_out});
        chk("yq", {31'h0, ey}, {31'h0, yq_out});
        @(posedge clk);
    endtask : store

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // ----
    // sequence
    // ----
    initial begin
        void'($urandom(16));
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            bus(1'h0, (i == 4) ? 4'h6 : 4'(i * 4), '0, 4'hF);
            chk("reset read", '0, rd);
        end
        bus(1'h1, LC_OFS_FIRST_TABLE, 32'hFFFFFFFF, 4'h1);
        bus(1'h0, LC_OFS_FIRST_TABLE, '0, 4'hF);
        chk("lane mask", 32'h000000FF, rd);
        logic_case(16'h6996, 16'h6996, 32'h00020096);
        for (int i = 0; i < 12; i++) begin
            logic_case(16'($urandom), 16'($urandom),
                       $urandom & 32'h603FF);
        end
        bus(1'h1, LC_OFS_CFG, 32'h00006CCC, 4'hF);
        store(2'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0);
        store(2'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
        store(2'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
        store(2'h2, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
        store(2'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
        store(2'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
        // storage fed from the table outputs, both ways round
        bus(1'h1, LC_OFS_FIRST_TABLE, 32'h0000FFFF, 4'hF);
        bus(1'h1, LC_OFS_SECOND_TABLE, 32'h00000000, 4'hF);
        bus(1'h1, LC_OFS_CFG, 32'h000004CC, 4'hF);
        store(2'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1);
        bus(1'h1, LC_OFS_CFG, 32'h000010CC, 4'hF);
        store(2'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
        bus(1'h1, LC_OFS_CFG, 32'h00016CCC, 4'hF);
        store(2'h3, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
        store(2'h3, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0);
        store(2'h3, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        summarize();
    end
endmodule : tb
